// file: hdl/eeprom_slave_pkg.sv
// Summary of operation
// - Hold data low through ninth clock
// - Standby at power-up, read stop, completion
// - Ignore everything during power-on reset
// - Brown-out resets, silent until power-on reset
// - Write-protect blocks array and identification page
// - Address byte: type, chip selects, direction
// - Type 1010 selects main array
// - Type 1011 selects identification page, unique id
// - Respond only when chip selects match pins
// - Address bit zero: one read, zero write
// - Acknowledge match, else not; then standby
// - Type 1011: lock on write, id on read
// - Two word address bytes, each acknowledged
// - Array location from word bits 12..0
// - Type 1011 decodes word bits 10 and 9
// - Unique id index from word bits 3..0
// - Start and stop are data edges, clock high
// - Sample on clock rise, drive on fall
// - Write-protected: acknowledge addresses, not data
// - Ignore the bus until a start
package eeprom_slave_pkg;
  localparam logic [3:0] TYPE_ARRAY = 4'ha;
  localparam logic [3:0] TYPE_IDPAGE = 4'hb;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int CS_MSB = 3;
  localparam int CS_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] BIT_BYTE_DONE = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE = 4'h9;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam int ARRAY_ADDR_W = 13;
  localparam int ID_BYTE_W = 5;
  localparam int UID_INDEX_W = 4;
  localparam int OP_MSB = 10;
  localparam int OP_LSB = 9;
  localparam logic [1:0] OP_PAGE = 2'h0;
  localparam logic [1:0] OP_UID = 2'h1;
  localparam logic [1:0] OP_LOCK = 2'h2;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV = 6'h02,
    ST_WA_HI = 6'h04,
    ST_WA_LO = 6'h08,
    ST_DATA = 6'h10,
    ST_READ = 6'h20
  } proto_state_e;
endpackage : eeprom_slave_pkg

// file: hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  initial begin
    if (WIDTH < 1) $error("pin_sync needs WIDTH of at least one");
  end

  // The first stage feeds only the second; nothing else looks at it
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule : pin_sync

// file: hdl/eeprom_slave_front.sv
`timescale 1ns/1ps
module eeprom_slave_front (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic chip_select_bit0_in,
  input wire logic chip_select_bit1_in,
  input wire logic chip_select_bit2_in,
  input wire logic wp_in,
  input wire logic por_active_in,
  input wire logic brown_out_threshold_in,
  input wire logic busy_in,
  output logic standby_out,
  output logic sel_array_out,
  output logic sel_idpage_out,
  output logic sel_lock_out,
  output logic sel_uid_out,
  output logic read_out,
  output logic addr_valid_out,
  output logic [eeprom_slave_pkg::ARRAY_ADDR_W-1:0] array_addr_out,
  output logic [eeprom_slave_pkg::ID_BYTE_W-1:0] id_byte_out,
  output logic [eeprom_slave_pkg::UID_INDEX_W-1:0] uid_index_out,
  output logic [7:0] data_byte_out,
  output logic data_valid_out,
  output logic write_blocked_out,
  output logic write_request_out
);
  import eeprom_slave_pkg::*;

  localparam int NSYNC = 8;

  logic [NSYNC-1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic por_s;
  logic bor_s;
  logic [2:0] cs_s;
  logic scl_prev_q;
  logic sda_prev_q;

  pin_sync #(
    .WIDTH(NSYNC)
  ) u_pin_sync (
    .clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .async_in({chip_select_bit2_in, chip_select_bit1_in, chip_select_bit0_in,
               brown_out_threshold_in, por_active_in, wp_in, sda_in, scl_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign wp_s = pins_s[2];
  assign por_s = pins_s[3];
  assign bor_s = pins_s[4];
  assign cs_s = pins_s[7:5];

  // Brown-out keeps the device silent until power-on reset cycles again
  logic dead_q;
  logic por_seen_q;
  logic dead_d;
  logic por_seen_d;
  assign dead_d = bor_s | (dead_q & ~(por_seen_q & ~por_s));
  assign por_seen_d = dead_q & (por_seen_q | por_s);

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      dead_q <= 1'b0;
      por_seen_q <= 1'b0;
    end else begin
      dead_q <= dead_d;
      por_seen_q <= por_seen_d;
    end
  end

  logic hold_off;
  assign hold_off = por_s | dead_q | bor_s;

  // Bus events from oversampled pins
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  proto_state_e state_q;
  proto_state_e state_d;
  proto_state_e next_q;
  proto_state_e next_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic rw_q;
  logic rw_d;
  logic is_id_q;
  logic is_id_d;
  logic [7:0] wa_hi_q;
  logic [7:0] wa_hi_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic drive_q;
  logic drive_d;

  // Address byte decode
  logic [3:0] byte_type;
  logic [2:0] byte_cs;
  logic type_known;
  logic dev_match;
  assign byte_type = shift_q[TYPE_MSB:TYPE_LSB];
  assign byte_cs = shift_q[CS_MSB:CS_LSB];
  assign type_known = (byte_type == TYPE_ARRAY) | (byte_type == TYPE_IDPAGE);
  // Busy write engine answers polls with not-acknowledge
  assign dev_match = type_known & (byte_cs == cs_s) & ~busy_in;

  logic byte_done;
  logic ack_done;
  assign byte_done = scl_fall & (bit_q == BIT_BYTE_DONE);
  assign ack_done = scl_fall & (bit_q == BIT_ACK_DONE);

  function automatic logic ack_for(input proto_state_e st, input logic match,
                                   input logic wp);
    case (st)
      ST_DEV: ack_for = match;
      ST_WA_HI: ack_for = 1'b1;
      ST_WA_LO: ack_for = 1'b1;
      ST_DATA: ack_for = ~wp;
      default: ack_for = 1'b0;
    endcase
  endfunction : ack_for

  function automatic proto_state_e after_byte(input proto_state_e st, input logic match,
                                              input logic rw);
    case (st)
      ST_DEV: after_byte = !match ? ST_IDLE : (rw == RW_READ ? ST_READ : ST_WA_HI);
      ST_WA_HI: after_byte = ST_WA_LO;
      ST_WA_LO: after_byte = ST_DATA;
      ST_DATA: after_byte = ST_DATA;
      ST_READ: after_byte = ST_READ;
      default: after_byte = ST_IDLE;
    endcase
  endfunction : after_byte

  logic take_data;
  assign take_data = byte_done & (state_q == ST_DATA) & ~wp_s;

  always_comb begin
    state_d = state_q;
    next_d = next_q;
    bit_d = bit_q;
    shift_d = shift_q;
    rw_d = rw_q;
    is_id_d = is_id_q;
    wa_hi_d = wa_hi_q;
    wr_pend_d = wr_pend_q;
    drive_d = drive_q;
    if (hold_off) begin
      state_d = ST_IDLE;
      bit_d = BIT_ZERO;
      drive_d = 1'b0;
      wr_pend_d = 1'b0;
    end else if (start_ev) begin
      // A repeated start also drops a pending write, so recovery never programs
      state_d = ST_DEV;
      bit_d = BIT_ZERO;
      drive_d = 1'b0;
      wr_pend_d = 1'b0;
    end else if (stop_ev) begin
      state_d = ST_IDLE;
      bit_d = BIT_ZERO;
      drive_d = 1'b0;
      wr_pend_d = 1'b0;
    end else if (state_q != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_q < BIT_BYTE_DONE) begin
          shift_d = {shift_q[6:0], sda_s};
        end
        bit_d = bit_q + BIT_ONE;
      end else if (byte_done) begin
        drive_d = ack_for(state_q, dev_match, wp_s);
        next_d = after_byte(state_q, dev_match, shift_q[RW_BIT]);
        if (state_q == ST_DEV) begin
          rw_d = shift_q[RW_BIT];
          is_id_d = (byte_type == TYPE_IDPAGE);
        end
        if (state_q == ST_WA_HI) begin
          wa_hi_d = shift_q;
        end
        if (take_data) begin
          wr_pend_d = 1'b1;
        end
      end else if (ack_done) begin
        // Released on the fall that ends the ninth clock
        drive_d = 1'b0;
        bit_d = BIT_ZERO;
        state_d = next_q;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      next_q <= ST_IDLE;
      bit_q <= BIT_ZERO;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      is_id_q <= 1'b0;
      wa_hi_q <= 8'h00;
      wr_pend_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      next_q <= next_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      rw_q <= rw_d;
      is_id_q <= is_id_d;
      wa_hi_q <= wa_hi_d;
      wr_pend_q <= wr_pend_d;
      drive_q <= drive_d;
    end
  end

  // Word address decode once both bytes are in
  logic [15:0] word_addr;
  logic [1:0] id_op;
  logic addr_load;
  assign word_addr = {wa_hi_q, shift_q};
  assign id_op = word_addr[OP_MSB:OP_LSB];
  assign addr_load = byte_done & (state_q == ST_WA_LO) & ~hold_off;

  logic sel_array_d;
  logic sel_idpage_d;
  logic sel_lock_d;
  logic sel_uid_d;
  assign sel_array_d = ~is_id_q;
  assign sel_idpage_d = is_id_q & (id_op == OP_PAGE);
  assign sel_lock_d = is_id_q & (rw_q != RW_READ) & (id_op == OP_LOCK);
  assign sel_uid_d = is_id_q & (rw_q == RW_READ) & (id_op == OP_UID);

  logic write_go;
  // Only a stop in the clock after an acknowledged data byte commits the write;
  // that clock's own rise has already been counted as one bit
  assign write_go = stop_ev & ~hold_off & (state_q == ST_DATA) & wr_pend_q &
                    (bit_q == BIT_ONE);

  logic sda_zero_q;
  logic sda_oe_n_q;
  logic standby_q;
  logic sel_array_q;
  logic sel_idpage_q;
  logic sel_lock_q;
  logic sel_uid_q;
  logic read_q;
  logic addr_valid_q;
  logic [ARRAY_ADDR_W-1:0] array_addr_q;
  logic [ID_BYTE_W-1:0] id_byte_q;
  logic [UID_INDEX_W-1:0] uid_index_q;
  logic [7:0] data_byte_q;
  logic data_valid_q;
  logic write_blocked_q;
  logic write_request_q;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sda_zero_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      standby_q <= 1'b1;
      sel_array_q <= 1'b0;
      sel_idpage_q <= 1'b0;
      sel_lock_q <= 1'b0;
      sel_uid_q <= 1'b0;
      read_q <= 1'b0;
      addr_valid_q <= 1'b0;
      array_addr_q <= '0;
      id_byte_q <= '0;
      uid_index_q <= '0;
      data_byte_q <= 8'h00;
      data_valid_q <= 1'b0;
      write_blocked_q <= 1'b0;
      write_request_q <= 1'b0;
    end else begin
      sda_zero_q <= 1'b0;
      sda_oe_n_q <= ~drive_d;
      standby_q <= (state_d == ST_IDLE) & ~busy_in;
      addr_valid_q <= addr_load;
      data_valid_q <= take_data & ~hold_off;
      write_request_q <= write_go;
      write_blocked_q <= wp_s & ~rw_q & (state_q == ST_DATA);
      if (state_d == ST_IDLE) begin
        sel_array_q <= 1'b0;
        sel_idpage_q <= 1'b0;
        sel_lock_q <= 1'b0;
        sel_uid_q <= 1'b0;
        read_q <= 1'b0;
      end else if (addr_load) begin
        sel_array_q <= sel_array_d;
        sel_idpage_q <= sel_idpage_d;
        sel_lock_q <= sel_lock_d;
        sel_uid_q <= sel_uid_d;
        read_q <= rw_q;
        array_addr_q <= word_addr[ARRAY_ADDR_W-1:0];
        id_byte_q <= word_addr[ID_BYTE_W-1:0];
        uid_index_q <= word_addr[UID_INDEX_W-1:0];
      end else if (byte_done & (state_q == ST_DEV) & dev_match &
                   (shift_q[RW_BIT] == RW_READ)) begin
        // Reads without word address keep the last location
        sel_array_q <= (byte_type == TYPE_ARRAY);
        sel_uid_q <= (byte_type == TYPE_IDPAGE);
        read_q <= 1'b1;
      end
      if (take_data) begin
        data_byte_q <= shift_q;
      end
    end
  end

  assign sda_out = sda_zero_q;
  assign sda_oe_n_out = sda_oe_n_q;
  assign standby_out = standby_q;
  assign sel_array_out = sel_array_q;
  assign sel_idpage_out = sel_idpage_q;
  assign sel_lock_out = sel_lock_q;
  assign sel_uid_out = sel_uid_q;
  assign read_out = read_q;
  assign addr_valid_out = addr_valid_q;
  assign array_addr_out = array_addr_q;
  assign id_byte_out = id_byte_q;
  assign uid_index_out = uid_index_q;
  assign data_byte_out = data_byte_q;
  assign data_valid_out = data_valid_q;
  assign write_blocked_out = write_blocked_q;
  assign write_request_out = write_request_q;
endmodule : eeprom_slave_front

// file: tb/eeprom_slave_checker.sv
`timescale 1ns/1ps
module eeprom_slave_checker (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic por_active_in,
  input wire logic standby_out,
  input wire logic sel_array_out,
  input wire logic sel_idpage_out,
  input wire logic sel_lock_out,
  input wire logic sel_uid_out,
  input wire logic addr_valid_out,
  input wire logic data_valid_out,
  input wire logic write_blocked_out,
  input wire logic write_request_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  a_ack_low_level: assert property (
    !sda_oe_n_out |-> !sda_out) else $error("acknowledge drives high");
  a_ack_stands: assert property (
    $fell(sda_oe_n_out) |-> !sda_oe_n_out[*8] ##[1:1000] sda_oe_n_out)
    else $error("acknowledge too short or never released");
  a_steady_clock_high: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe_n_out))
    else $error("data drive changed while clock high");
  a_idle_quiet: assert property (
    standby_out |-> sda_oe_n_out) else $error("drive while idle");
  a_por_silent: assert property (
    por_active_in[*6] |-> sda_oe_n_out) else $error("drive during power-on reset");
  a_blocked_no_data: assert property (
    write_blocked_out |-> !data_valid_out && !write_request_out)
    else $error("protected write passed data");
  // Lock and unique id are selections too; a write to the read-only id block picks none
  a_addr_selects: assert property (
    addr_valid_out |-> ##1
      $onehot0({sel_array_out, sel_idpage_out, sel_lock_out, sel_uid_out}))
    else $error("address with more than one selection");
  a_write_on_stop: assert property (
    write_request_out |-> scl_in && sda_in && !$past(sda_in, 8))
    else $error("write request without stop");
  c_addr: cover property (addr_valid_out);
  c_write: cover property (write_request_out);
  c_blocked: cover property (write_blocked_out);
endmodule : eeprom_slave_checker
bind eeprom_slave_front eeprom_slave_checker i_chk (.core_clk_in(core_clk_in),
  .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out), .por_active_in(por_active_in),
  .standby_out(standby_out), .sel_array_out(sel_array_out),
  .sel_idpage_out(sel_idpage_out), .sel_lock_out(sel_lock_out),
  .sel_uid_out(sel_uid_out), .addr_valid_out(addr_valid_out),
  .data_valid_out(data_valid_out), .write_blocked_out(write_blocked_out),
  .write_request_out(write_request_out));

// file: tb/two_wire_master.sv
`timescale 1ns/1ps
module two_wire_master (
  input wire logic link_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // Released lines idle high through the pull-up; clock stands still outside frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Ten link cycles a phase keeps well above the core's oversampling need
  task automatic wt();
    repeat (10) @(posedge link_clk_in);
    #1;
  endtask : wt
  task automatic start();
    sda_out = 1'b1;
    wt();
    scl_out = 1'b1;
    wt();
    sda_out = 1'b0;
    wt();
    scl_out = 1'b0;
    wt();
  endtask : start
  task automatic stop();
    sda_out = 1'b0;
    wt();
    scl_out = 1'b1;
    wt();
    sda_out = 1'b1;
    wt();
  endtask : stop
  task automatic bit_cycle(input logic b, output logic r);
    sda_out = b;
    wt();
    scl_out = 1'b1;
    wt();
    r = sda_in;
    scl_out = 1'b0;
    wt();
  endtask : bit_cycle
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
    bit_cycle(1'b1, r);
    ack = !r;
  endtask : send
endmodule : two_wire_master

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import eeprom_slave_pkg::*;
  typedef struct {logic [7:0] dev; logic [15:0] wa; logic wp; logic ack; logic [2:0] sel;} row_s;
  logic core_clk_in = 1'b0, link_clk = 1'b0, resetn_in = 1'b0, scl_in, m_sda, sda_in, r;
  logic chip_select_bit0_in = 1'b1, chip_select_bit1_in = 1'b0, chip_select_bit2_in = 1'b1;
  logic wp_in = 1'b0, por_active_in = 1'b0, brown_out_threshold_in = 1'b0, busy_in = 1'b0;
  logic sda_out, sda_oe_n_out, standby_out, sel_array_out, sel_idpage_out, sel_lock_out;
  logic sel_uid_out, read_out, addr_valid_out, data_valid_out, write_blocked_out;
  logic write_request_out;
  logic [ARRAY_ADDR_W-1:0] array_addr_out;
  logic [ID_BYTE_W-1:0] id_byte_out;
  logic [UID_INDEX_W-1:0] uid_index_out;
  logic [7:0] data_byte_out, data_q;
  logic [21:0] cap;
  int num_errors = 0, compares = 0, n_wr = 0;
  // Chip selects wired to 101, so matching address bytes carry 101 in bits 3..1
  row_s rows[9] = '{'{8'haa, 16'he5a3, 0, 1, 3'h4}, '{8'hba, 16'hf9ff, 1, 1, 3'h0},
    '{8'hba, 16'h0400, 0, 1, 3'h2}, '{8'hba, 16'h7a0b, 0, 1, 3'h0},
    '{8'hab, 16'h0, 1, 1, 3'h4}, '{8'hbb, 16'h0, 0, 1, 3'h1}, '{8'ha8, 16'h0, 0, 0, 3'h0},
    '{8'h9a, 16'h0, 0, 0, 3'h0}, '{8'hea, 16'h0, 0, 0, 3'h0}};
  assign sda_in = m_sda & (sda_oe_n_out | sda_out);
  eeprom_slave_front i_dut (.*);
  two_wire_master i_mst (.link_clk_in(link_clk), .sda_in(sda_in), .scl_out(scl_in),
    .sda_out(m_sda));
  always #2.5 core_clk_in = ~core_clk_in;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge core_clk_in) begin
    if (addr_valid_out) cap = {array_addr_out, id_byte_out, uid_index_out};
    if (data_valid_out) data_q = data_byte_out;
    if (write_request_out) n_wr++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic run_row(input row_s w);
    logic a;
    int w0;
    tick(1);
    wp_in = w.wp;
    w0 = n_wr;
    cap = '1;
    i_mst.start();
    i_mst.send(w.dev, a);
    check(a, w.ack);
    if (a && !w.dev[0]) begin
      i_mst.send(w.wa[15:8], a);
      check(a, 1);
      i_mst.send(w.wa[7:0], a);
      check(a, 1);
      check(cap, {w.wa[12:0], w.wa[4:0], w.wa[3:0]});
      check({sel_array_out, sel_lock_out, sel_uid_out}, w.sel);
      check(sel_idpage_out, w.dev[4] && (w.wa[10:9] == 2'b00));
      i_mst.send(8'h5a, a);
      check(a, !w.wp);
      check(write_blocked_out, w.wp);
      if (!w.wp) check(data_q, 8'h5a);
    end else if (a) begin
      check({sel_array_out, sel_uid_out, read_out}, {w.sel[2], w.sel[0], 1'b1});
    end
    i_mst.stop();
    tick(2);
    check(n_wr - w0, (w.ack && !w.dev[0] && !w.wp) ? 1 : 0);
    // A running write cycle keeps the device out of standby
    check(standby_out, !busy_in);
  endtask : run_row
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #300us;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic a;
    row_s quiet;
    // A matching write address that the device must still leave unanswered
    quiet = '{8'haa, 16'he5a3, 1'b0, 1'b0, 3'h0};
    tick(10);
    check({standby_out, sda_oe_n_out}, 2'h3);
    resetn_in = 1'b1;
    tick(4);
    foreach (rows[i]) run_row(rows[i]);
    busy_in = 1'b1;
    run_row(quiet);
    busy_in = 1'b0;
    por_active_in = 1'b1;
    tick(8);
    run_row(quiet);
    por_active_in = 1'b0;
    brown_out_threshold_in = 1'b1;
    tick(8);
    brown_out_threshold_in = 1'b0;
    tick(8);
    run_row(quiet);
    por_active_in = 1'b1;
    tick(8);
    por_active_in = 1'b0;
    tick(8);
    run_row(rows[0]);
    i_mst.start();
    i_mst.send(8'haa, a);
    i_mst.send(8'h00, a);
    i_mst.send(8'h01, a);
    i_mst.send(8'h5a, a);
    // Recovery cuts in before the stop, so no write may follow
    i_mst.start();
    repeat (9) i_mst.bit_cycle(1'b1, a);
    i_mst.start();
    i_mst.stop();
    tick(4);
    // Writes so far: rows 0, 2 and 3, and row 0 again after power-on reset
    check(n_wr, 4);
    check(standby_out, 1);
    tally_and_finish();
  end
endmodule : tb
